// *** core/edfoc_top.sv ***
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "edfoc_consts.svh"

// Overview of operation
// R01: Threshold zero means store-and-forward: start on whole frame or full FIFO.
// R02: Nonzero threshold counts in bytes as four times the field value.
// R03: Start transmit on level above threshold, FIFO full, or frame written.
// R04: Software changes the threshold only while transmission is halted.
// R05: Software keeps the threshold below the transmit FIFO capacity.
// R06: Transmit FIFO depth is (code+1) times 256 bytes, reset code 0.
// R07: Receive FIFO depth is (code+1) times 256 bytes, reset code 0.
// R08: Depth settings are frozen once transmission or reception has started.
// R09: Reserved bits read zero; software writes zero to them.
// R10: Software changes receive continuation only while reception is halted.
// R11: Continuation off: write status, then clear the receive request bit.
// R12: Continuation on: write status, fetch next descriptor, keep receiving.
// R13: FIFO error halt bit chooses continue or halt on underflow/overflow.
// R14: Illegal descriptor address sets a sticky flag, cleared by writing zero.
// R15: Non-maskable interrupt halts and sets halted flag; writing zero restarts.
// R16: While halted, no descriptor fetches or buffer transfers are started.
module edfoc_top
    import edfoc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Transmit FIFO traffic
    input wire logic tx_push_i,
    input wire logic tx_frame_end_i,
    input wire logic tx_pop_i,
    output logic tx_start_o,
    output logic tx_xfer_en_o,
    // Receive FIFO traffic
    input wire logic rx_push_i,
    input wire logic rx_pop_i,
    input wire logic rx_frame_done_i,
    output logic rx_enable_o,
    // Memory requests for receive completion
    output logic mem_req_o,
    output logic mem_fetch_o,
    input wire logic mem_ack_i,
    // Error sources
    input wire logic addr_err_i,
    input wire logic nmi_i,
    // Interrupt
    output logic irq_o
);
    // ==========================================================
    // Fill trackers
    edfoc_fill_if tx_if ();
    edfoc_fill_if rx_if ();

    edfoc_fill #(.LEVEL_W(`EDFOC_LEVEL_W)) u_tx_fill (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .fif(tx_if.tracker)
    );
    edfoc_fill #(.LEVEL_W(`EDFOC_LEVEL_W)) u_rx_fill (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .fif(rx_if.tracker)
    );

    // ==========================================================
    // State
    logic [10:0] thr, next_thr;
    logic [2:0] tx_depth, next_tx_depth;
    logic [2:0] rx_depth, next_rx_depth;
    logic rx_cont, next_rx_cont;
    logic err_halt, next_err_halt;
    logic addr_flag, next_addr_flag;
    logic halted, next_halted;
    logic rx_req, next_rx_req;
    logic started, next_started;
    logic frame_seen, next_frame_seen;
    logic [4:0] int_stat, next_int_stat;
    logic [4:0] int_mask, next_int_mask;
    logic [31:0] next_rdata;
    logic next_tx_start;
    logic next_irq;
    edfoc_rx_state_e rx_state, next_rx_state;
    logic next_mem_req, next_mem_fetch;
    logic wr_thr, wr_depth, wr_cont, wr_op, wr_req, wr_stat, wr_mask;
    logic fifo_err;
    logic [4:0] events;
    logic status_done;

    assign tx_if.push = tx_push_i;
    assign tx_if.pop = tx_pop_i;
    assign tx_if.depth_code = tx_depth;
    assign rx_if.push = rx_push_i;
    assign rx_if.pop = rx_pop_i;
    assign rx_if.depth_code = rx_depth;

    // Write decode
    always_comb
    begin
        wr_thr = 1'b0;
        wr_depth = 1'b0;
        wr_cont = 1'b0;
        wr_op = 1'b0;
        wr_req = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        if (reg_wr_i && reg_addr_i == `EDFOC_OFS_TX_THRESH)
            wr_thr = 1'b1;
        else if (reg_wr_i && reg_addr_i == `EDFOC_OFS_DEPTH)
            wr_depth = 1'b1;
        else if (reg_wr_i && reg_addr_i == `EDFOC_OFS_RX_CONT)
            wr_cont = 1'b1;
        else if (reg_wr_i && reg_addr_i == `EDFOC_OFS_OP_CTRL)
            wr_op = 1'b1;
        else if (reg_wr_i && reg_addr_i == `EDFOC_OFS_RX_REQ)
            wr_req = 1'b1;
        else if (reg_wr_i && reg_addr_i == `EDFOC_OFS_INT_STAT)
            wr_stat = 1'b1;
        else if (reg_wr_i && reg_addr_i == `EDFOC_OFS_INT_MASK)
            wr_mask = 1'b1;
    end

    // Underflow on transmit, overflow on receive
    assign fifo_err = tx_if.pop_lost || rx_if.push_lost;
    assign status_done = (rx_state == RX_STATUS) && mem_ack_i;
    assign events = {status_done, nmi_i, addr_err_i, rx_if.push_lost, tx_if.pop_lost};

    // ==========================================================
    // Control registers
    always_comb
    begin
        next_thr = thr;
        next_tx_depth = tx_depth;
        next_rx_depth = rx_depth;
        next_rx_cont = rx_cont;
        next_err_halt = err_halt;
        next_addr_flag = addr_flag;
        next_halted = halted;
        next_int_mask = int_mask;
        // Threshold is trusted to be written while halted
        if (wr_thr)
            next_thr = reg_wdata_i[`EDFOC_THR_W-1:0]; // R04 R05
        // Depth silently ignored after start; avoids resizing live data
        if (wr_depth && !started)
        begin
            next_tx_depth = reg_wdata_i[`EDFOC_TXD_LSB +: 3]; // R08
            next_rx_depth = reg_wdata_i[`EDFOC_RXD_LSB +: 3];
        end
        if (wr_cont)
            next_rx_cont = reg_wdata_i[`EDFOC_RX_CONT_BIT]; // R10
        if (wr_op)
        begin
            next_err_halt = reg_wdata_i[`EDFOC_ERR_HALT_BIT];
            // Writing one leaves the flags alone, writing zero clears
            if (!reg_wdata_i[`EDFOC_ADDR_FLAG_BIT])
                next_addr_flag = 1'b0;
            if (!reg_wdata_i[`EDFOC_HALTED_BIT])
                next_halted = 1'b0;
        end
        if (wr_mask)
            next_int_mask = reg_wdata_i[`EDFOC_INT_W-1:0];
        // Sets win over clears
        if (addr_err_i)
            next_addr_flag = 1'b1; // R14
        if (nmi_i || (err_halt && fifo_err))
            next_halted = 1'b1; // R13 R15
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            thr <= `EDFOC_RST_THR;
            tx_depth <= `EDFOC_RST_DEPTH;
            rx_depth <= `EDFOC_RST_DEPTH;
            rx_cont <= 1'b0;
            err_halt <= 1'b0;
            addr_flag <= 1'b0;
            halted <= 1'b0;
            int_mask <= '0;
        end
        else
        begin
            thr <= next_thr;
            tx_depth <= next_tx_depth;
            rx_depth <= next_rx_depth;
            rx_cont <= next_rx_cont;
            err_halt <= next_err_halt;
            addr_flag <= next_addr_flag;
            halted <= next_halted;
            int_mask <= next_int_mask;
        end
    end

    // ==========================================================
    // Receive completion sequencer and request bit
    always_comb
    begin
        next_rx_state = rx_state;
        next_rx_req = rx_req;
        next_mem_req = mem_req_o;
        next_mem_fetch = mem_fetch_o;
        if (wr_req && reg_wdata_i[`EDFOC_RX_REQ_BIT])
            next_rx_req = 1'b1;
        case (rx_state)
            RX_IDLE:
            begin
                if (rx_frame_done_i && rx_req)
                    next_rx_state = RX_STATUS;
            end
            RX_STATUS:
            begin
                // No new request while halted; one in flight completes
                if (!mem_req_o && !halted)
                begin
                    next_mem_req = 1'b1; // R16
                    next_mem_fetch = 1'b0;
                end
                else if (mem_ack_i)
                begin
                    next_mem_req = 1'b0;
                    if (rx_cont)
                        next_rx_state = RX_FETCH; // R12
                    else
                    begin
                        next_rx_req = 1'b0; // R11
                        next_rx_state = RX_IDLE;
                    end
                end
            end
            RX_FETCH:
            begin
                if (!mem_req_o && !halted)
                begin
                    next_mem_req = 1'b1; // R16
                    next_mem_fetch = 1'b1;
                end
                else if (mem_ack_i)
                begin
                    next_mem_req = 1'b0;
                    next_mem_fetch = 1'b0;
                    next_rx_state = RX_IDLE;
                end
            end
            default:
                next_rx_state = RX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            rx_state <= RX_IDLE;
            rx_req <= 1'b0;
            mem_req_o <= 1'b0;
            mem_fetch_o <= 1'b0;
        end
        else
        begin
            rx_state <= next_rx_state;
            rx_req <= next_rx_req;
            mem_req_o <= next_mem_req;
            mem_fetch_o <= next_mem_fetch;
        end
    end

    // ==========================================================
    // Transmit start, status, interrupt and read data
    always_comb
    begin
        next_started = started || rx_req || tx_push_i || rx_push_i;
        next_frame_seen = frame_seen;
        // Whole frame latched until the FIFO drains
        if (tx_push_i && tx_frame_end_i)
            next_frame_seen = 1'b1;
        else if (tx_if.empty)
            next_frame_seen = 1'b0;
        next_tx_start = tx_if.full || frame_seen; // R01 R03
        if (thr != '0 && {1'b0, tx_if.level} > {thr, 2'b00})
            next_tx_start = 1'b1; // R02
        next_int_stat = int_stat;
        if (wr_stat)
            next_int_stat = int_stat & ~reg_wdata_i[`EDFOC_INT_W-1:0];
        next_int_stat = next_int_stat | events;
        next_irq = |(int_stat & int_mask);
        next_rdata = '0;
        // Unmapped addresses and reserved bits read zero
        if (reg_rd_i && reg_addr_i == `EDFOC_OFS_TX_THRESH)
            next_rdata[`EDFOC_THR_W-1:0] = thr;
        else if (reg_rd_i && reg_addr_i == `EDFOC_OFS_DEPTH)
        begin
            next_rdata[`EDFOC_TXD_LSB +: 3] = tx_depth; // R09
            next_rdata[`EDFOC_RXD_LSB +: 3] = rx_depth;
        end
        else if (reg_rd_i && reg_addr_i == `EDFOC_OFS_RX_CONT)
            next_rdata[`EDFOC_RX_CONT_BIT] = rx_cont;
        else if (reg_rd_i && reg_addr_i == `EDFOC_OFS_OP_CTRL)
        begin
            next_rdata[`EDFOC_ERR_HALT_BIT] = err_halt;
            next_rdata[`EDFOC_ADDR_FLAG_BIT] = addr_flag;
            next_rdata[`EDFOC_HALTED_BIT] = halted;
        end
        else if (reg_rd_i && reg_addr_i == `EDFOC_OFS_RX_REQ)
            next_rdata[`EDFOC_RX_REQ_BIT] = rx_req;
        else if (reg_rd_i && reg_addr_i == `EDFOC_OFS_INT_STAT)
            next_rdata[`EDFOC_INT_W-1:0] = int_stat;
        else if (reg_rd_i && reg_addr_i == `EDFOC_OFS_INT_MASK)
            next_rdata[`EDFOC_INT_W-1:0] = int_mask;
        else if (reg_rd_i && reg_addr_i == `EDFOC_OFS_LEVELS)
        begin
            next_rdata[`EDFOC_LEVEL_W-1:0] = tx_if.level;
            next_rdata[`EDFOC_LVL_RX_LSB +: `EDFOC_LEVEL_W] = rx_if.level;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            started <= 1'b0;
            frame_seen <= 1'b0;
            tx_start_o <= 1'b0;
            int_stat <= '0;
            irq_o <= 1'b0;
            reg_rdata_o <= '0;
            tx_xfer_en_o <= 1'b0;
            rx_enable_o <= 1'b0;
        end
        else
        begin
            started <= next_started;
            frame_seen <= next_frame_seen;
            tx_start_o <= next_tx_start;
            int_stat <= next_int_stat;
            irq_o <= next_irq;
            reg_rdata_o <= next_rdata;
            tx_xfer_en_o <= !next_halted; // R16
            rx_enable_o <= next_rx_req && !next_halted;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    AST_STORE_FWD: assert property ( // R01
        (thr == '0 && !tx_if.full && !frame_seen) |=> !tx_start_o)
        else $error("transmit started early in store-and-forward");
    AST_THRESH: assert property ( // R02
        (thr != '0 && {1'b0, tx_if.level} > {thr, 2'b00}) |=> tx_start_o)
        else $error("transmit not started above threshold");
    AST_FULL_START: assert property ((tx_if.full || frame_seen) |=> tx_start_o) // R03
        else $error("transmit not started on full or whole frame");
    AST_DEPTH_LOCK: assert property ( // R08
        (started && wr_depth) |=> $stable(tx_depth) && $stable(rx_depth))
        else $error("depth changed after start");
    AST_RSVD: assert property ( // R09
        (reg_rd_i && reg_addr_i == `EDFOC_OFS_DEPTH)
        |=> reg_rdata_o[31:11] == '0 && reg_rdata_o[7:3] == '0)
        else $error("reserved depth bits read nonzero");
    AST_REQ_CLEAR: assert property ( // R11
        (status_done && !rx_cont && !wr_req) |=> !rx_req && rx_state == RX_IDLE)
        else $error("request bit not cleared after frame");
    AST_CONT_FETCH: assert property ( // R12
        (status_done && rx_cont) |=> rx_state == RX_FETCH ##[1:2] (mem_req_o || halted))
        else $error("next descriptor not fetched");
    AST_ERR_HALT: assert property ((err_halt && fifo_err) |=> halted && !tx_xfer_en_o) // R13
        else $error("FIFO error did not halt");
    AST_ADDR_FLAG_SET: assert property ( // R14
        addr_err_i |=> addr_flag [*2] or (addr_flag ##1 !addr_flag))
        else $error("address error flag not set");
    AST_NMI_HALT: assert property (nmi_i |=> halted ##1 !rx_enable_o) // R15
        else $error("non-maskable interrupt did not halt");
    AST_NO_REQ_HALT: assert property ((halted && !mem_req_o) |=> !mem_req_o) // R16
        else $error("memory request started while halted");
endmodule

// *** core/edfoc_consts.svh ***
`ifndef EDFOC_CONSTS_SVH
`define EDFOC_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define EDFOC_OFS_TX_THRESH 8'h00
`define EDFOC_OFS_DEPTH 8'h04
`define EDFOC_OFS_RX_CONT 8'h08
`define EDFOC_OFS_OP_CTRL 8'h0C
`define EDFOC_OFS_RX_REQ 8'h10
`define EDFOC_OFS_INT_STAT 8'h14
`define EDFOC_OFS_INT_MASK 8'h18
`define EDFOC_OFS_LEVELS 8'h1C

// ==========================================================
// Field positions and widths
`define EDFOC_THR_W 11
`define EDFOC_TXD_LSB 8
`define EDFOC_RXD_LSB 0
`define EDFOC_DEPTH_CODE_W 3
`define EDFOC_ERR_HALT_BIT 3
`define EDFOC_ADDR_FLAG_BIT 2
`define EDFOC_HALTED_BIT 1
`define EDFOC_RX_CONT_BIT 0
`define EDFOC_RX_REQ_BIT 0
`define EDFOC_LVL_RX_LSB 16

// ==========================================================
// Interrupt status bits
`define EDFOC_INT_W 5
`define EDFOC_INT_TX_UNDER 0
`define EDFOC_INT_RX_OVER 1
`define EDFOC_INT_ADDR_ERR 2
`define EDFOC_INT_HALT 3
`define EDFOC_INT_RX_DONE 4

// ==========================================================
// Reset values and sizing
`define EDFOC_RST_THR 11'h000
`define EDFOC_RST_DEPTH 3'h0
`define EDFOC_LEVEL_W 12
`define EDFOC_DEPTH_STEP 12'h100
`define EDFOC_WORD_BYTES 12'h004

`endif

// *** core/edfoc_pkg.sv ***
package edfoc_pkg;

    // ==========================================================
    // Receive completion sequencer states
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_STATUS,
        RX_FETCH
    } edfoc_rx_state_e;

    typedef logic [31:0] edfoc_word_t;

endpackage

// *** core/edfoc_fill_if.sv ***
`timescale 1ns/1ps

// ==========================================================
// Fill-level tracker connection
interface edfoc_fill_if;
    logic push;
    logic pop;
    logic [2:0] depth_code;
    logic [11:0] level;
    logic full;
    logic empty;
    logic push_lost;
    logic pop_lost;

    modport tracker (
        input push, pop, depth_code,
        output level, full, empty, push_lost, pop_lost
    );
    modport owner (
        output push, pop, depth_code,
        input level, full, empty, push_lost, pop_lost
    );
endinterface

// *** core/edfoc_fill.sv ***
`timescale 1ns/1ps
`include "edfoc_consts.svh"

// ==========================================================
// Byte fill level of one FIFO, sized by a depth code
module edfoc_fill
    import edfoc_pkg::*;
#(
    parameter int LEVEL_W = `EDFOC_LEVEL_W
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Owner side
    edfoc_fill_if.tracker fif
);
    logic [LEVEL_W-1:0] level;
    logic [LEVEL_W-1:0] next_level;
    logic [LEVEL_W-1:0] cap;
    logic add_ok;
    logic sub_ok;

    // Capacity is (code + 1) steps of 256 bytes
    assign cap = LEVEL_W'({1'b0, fif.depth_code} + 4'h1) * LEVEL_W'(`EDFOC_DEPTH_STEP);
    assign fif.full = (level >= cap); // R06 R07
    assign fif.empty = (level == '0);
    assign fif.level = level;
    assign add_ok = fif.push && !fif.full;
    assign sub_ok = fif.pop && !fif.empty;
    // Lost pops on transmit and lost pushes on receive feed the underflow and overflow logic upstream
    assign fif.push_lost = fif.push && fif.full;
    assign fif.pop_lost = fif.pop && fif.empty;

    // Next level: a simultaneous push and pop cancel out only when both are accepted
    always_comb
    begin
        next_level = level;
        if (add_ok && !sub_ok)
        begin
            next_level = level + LEVEL_W'(`EDFOC_WORD_BYTES);
        end
        else if (sub_ok && !add_ok)
        begin
            next_level = level - LEVEL_W'(`EDFOC_WORD_BYTES);
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            level <= '0;
        end
        else
        begin
            level <= next_level;
        end
    end

    AST_FULL_AT_CAP: assert property (@(posedge core_clk_i) disable iff (reset_i) // R06
        (level <= cap) && (fif.full == (level == cap)))
        else $error("fill level beyond capacity or full flag wrong");
    AST_NO_PAST_CAP: assert property (@(posedge core_clk_i) disable iff (reset_i) // R07
        fif.full && !fif.pop |=> level == $past(level) || level < $past(level))
        else $error("fill level grew past capacity");
endmodule

// *** bench/edfoc_mem_model.sv ***
`timescale 1ns/1ps

// ==========================================================
// Memory bus responder for receive completion requests
module edfoc_mem_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Request side
    input wire logic mem_req_i,
    input wire logic mem_fetch_i,
    input wire logic [3:0] lat_i,
    output logic mem_ack_o,
    // Served request counts
    output int n_status_o,
    output int n_fetch_o
);
    logic [3:0] wait_cnt;

    // Ack after lat_i waiting cycles; a one-cycle pulse, never a held level
    always @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            mem_ack_o <= 1'h0;
            wait_cnt <= 4'h0;
            n_status_o <= 0;
            n_fetch_o <= 0;
        end
        else if (mem_ack_o)
        begin
            mem_ack_o <= 1'h0;
        end
        else if (mem_req_i)
        begin
            if (wait_cnt == lat_i)
            begin
                mem_ack_o <= 1'h1;
                wait_cnt <= 4'h0;
                if (mem_fetch_i)
                    n_fetch_o <= n_fetch_o + 1;
                else
                    n_status_o <= n_status_o + 1;
            end
            else
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ps

// ==========================================================
// Register-driven bench for FIFO and operation control
module tb_top;
    logic core_clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [31:0] reg_rdata_o;
    logic reg_wr_i = 1'h0, reg_rd_i = 1'h0, tx_push_i = 1'h0, tx_frame_end_i = 1'h0;
    logic tx_pop_i = 1'h0, rx_push_i = 1'h0, rx_pop_i = 1'h0, rx_frame_done_i = 1'h0;
    logic addr_err_i = 1'h0, nmi_i = 1'h0;
    logic tx_start_o, tx_xfer_en_o, rx_enable_o, mem_req_o, mem_fetch_o, mem_ack_i, irq_o;
    logic [3:0] lat = 4'h0;
    logic a;
    int bad_count = 0, n_tests = 0, ns, nf;
    logic [7:0] ta [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
    logic [31:0] te [5] = '{32'h7FF, 32'h707, 32'h1, 32'h8, 32'h0};

    always #50 core_clk_i = ~core_clk_i;

    edfoc_top DUT (.core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .tx_push_i, .tx_frame_end_i, .tx_pop_i, .tx_start_o, .tx_xfer_en_o,
        .rx_push_i, .rx_pop_i, .rx_frame_done_i, .rx_enable_o, .mem_req_o, .mem_fetch_o,
        .mem_ack_i, .addr_err_i, .nmi_i, .irq_o);

    edfoc_mem_model MEM (.core_clk_i, .reset_i, .mem_req_i(mem_req_o),
        .mem_fetch_i(mem_fetch_o), .lat_i(lat), .mem_ack_o(mem_ack_i),
        .n_status_o(ns), .n_fetch_o(nf));

    // ==========================================================
    // Shared tasks
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wr(input logic [7:0] ad, input logic [31:0] v);
        @(posedge core_clk_i);
        reg_addr_i <= ad;
        reg_wdata_i <= v;
        reg_wr_i <= 1'h1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e, input string nm);
        @(posedge core_clk_i);
        reg_addr_i <= ad;
        reg_rd_i <= 1'h1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'h0;
        #1;
        chk(nm, e, reg_rdata_o & m);
    endtask

    task cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    // Event input held high for n cycles in a row; frame end marks the last push only
    task pulse(input int sel, input int n, input logic fe);
        for (int i = 0; i < n; i++)
        begin
            @(posedge core_clk_i);
            case (sel)
                0: tx_push_i <= 1'h1;
                1: tx_pop_i <= 1'h1;
                2: rx_push_i <= 1'h1;
                3: rx_pop_i <= 1'h1;
                4: nmi_i <= 1'h1;
                5: addr_err_i <= 1'h1;
                default: rx_frame_done_i <= 1'h1;
            endcase
            tx_frame_end_i <= fe && (i == n - 1);
        end
        @(posedge core_clk_i);
        {tx_push_i, tx_pop_i, rx_push_i, rx_pop_i, nmi_i, addr_err_i} <= 6'h00;
        {rx_frame_done_i, tx_frame_end_i} <= 2'h0;
    endtask

    // Bounded wait on the memory request level
    task wait_req(input logic v);
        int k;
        k = 0;
        while ((mem_req_o !== v) && (k < 60))
        begin
            cyc(1);
            k++;
        end
        if (k == 60)
        begin
            bad_count++;
            $display("FAIL mem_req_o expected %h seen %h", v, mem_req_o);
            complete_run();
        end
    endtask

    task done(input string nm);
        $display("test %s finished", nm);
    endtask

    task complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if ((bad_count == 0) && (n_tests > 0))
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'h0;
        for (int i = 0; i < 9; i++)
            rd(8'(i * 4), 32'hFFFFFFFF, 32'h0, "reset value");
        chk("xfer_en", 32'h1, tx_xfer_en_o);
        done("reset");
        // All ones written; only defined fields come back
        for (int i = 0; i < 5; i++)
        begin
            wr(ta[i], 32'hFFFFFFFF);
            rd(ta[i], 32'hFFFFFFFF, te[i], "reserved");
            wr(ta[i], 32'h0);
        end
        done("reserved");
        pulse(0, 3, 1'h0);
        cyc(3);
        chk("start no frame", 32'h0, tx_start_o);
        pulse(0, 1, 1'h1);
        cyc(3);
        chk("start frame", 32'h1, tx_start_o);
        pulse(1, 4, 1'h0);
        cyc(3);
        chk("start drained", 32'h0, tx_start_o);
        wr(8'h04, 32'h707);
        rd(8'h04, 32'hFFFFFFFF, 32'h0, "depth frozen");
        done("store and forward");
        // Code 0 gives 64 words; the 65th push is refused
        pulse(0, 63, 1'h0);
        cyc(3);
        chk("start not full", 32'h0, tx_start_o);
        pulse(0, 2, 1'h0);
        cyc(3);
        chk("start full", 32'h1, tx_start_o);
        rd(8'h1C, 32'hFFF, 32'h100, "tx level");
        pulse(1, 65, 1'h0);
        rd(8'h14, 32'h1, 32'h1, "underflow");
        rd(8'h0C, 32'hFFFFFFFF, 32'h0, "no halt");
        done("tx full");
        wr(8'h00, 32'h2);
        pulse(0, 2, 1'h0);
        cyc(3);
        chk("start at 8", 32'h0, tx_start_o);
        pulse(0, 1, 1'h0);
        cyc(3);
        chk("start at 12", 32'h1, tx_start_o);
        pulse(1, 3, 1'h0);
        wr(8'h00, 32'h0);
        done("threshold");
        pulse(2, 65, 1'h0);
        rd(8'h1C, 32'hFFF0000, 32'h1000000, "rx level");
        rd(8'h14, 32'h2, 32'h2, "overflow");
        pulse(3, 64, 1'h0);
        wr(8'h0C, 32'h8);
        pulse(1, 1, 1'h0);
        rd(8'h0C, 32'hFFFFFFFF, 32'hA, "fifo halt");
        chk("xfer halted", 32'h0, tx_xfer_en_o);
        wr(8'h0C, 32'h8);
        rd(8'h0C, 32'hFFFFFFFF, 32'h8, "restart");
        chk("xfer restart", 32'h1, tx_xfer_en_o);
        done("fifo error");
        pulse(5, 1, 1'h0);
        rd(8'h0C, 32'hFFFFFFFF, 32'hC, "addr err set");
        wr(8'h0C, 32'hC);
        rd(8'h0C, 32'hFFFFFFFF, 32'hC, "addr err sticky");
        wr(8'h0C, 32'h0);
        rd(8'h0C, 32'hFFFFFFFF, 32'h0, "addr err clear");
        done("address error");
        // A set mask bit lets its status bit through to the interrupt
        wr(8'h18, 32'h0);
        cyc(2);
        a = irq_o;
        wr(8'h18, 32'h1F);
        cyc(2);
        chk("irq masked", 32'h0, a);
        chk("irq unmasked", 32'h1, irq_o);
        wr(8'h14, 32'h1F);
        rd(8'h14, 32'h1F, 32'h0, "status cleared");
        cyc(2);
        chk("irq clear", 32'h0, irq_o);
        wr(8'h18, 32'h0);
        cyc(2);
        chk("irq clear unmasked", 32'h0, irq_o);
        done("interrupt");
        wr(8'h10, 32'h1);
        cyc(2);
        chk("rx enable", 32'h1, rx_enable_o);
        pulse(6, 1, 1'h0);
        wait_req(1'h1);
        wait_req(1'h0);
        cyc(3);
        chk("status writes", 32'h1, ns);
        chk("fetches", 32'h0, nf);
        rd(8'h10, 32'hFFFFFFFF, 32'h0, "request cleared");
        chk("rx stopped", 32'h0, rx_enable_o);
        rd(8'h14, 32'h10, 32'h10, "rx status irq");
        done("rx single");
        lat <= 4'h5;
        wr(8'h08, 32'h1);
        wr(8'h10, 32'h1);
        pulse(6, 1, 1'h0);
        wait_req(1'h1);
        wait_req(1'h0);
        wait_req(1'h1);
        wait_req(1'h0);
        cyc(3);
        chk("status writes", 32'h2, ns);
        chk("fetches", 32'h1, nf);
        rd(8'h10, 32'hFFFFFFFF, 32'h1, "request kept");
        done("rx continuous");
        pulse(4, 1, 1'h0);
        rd(8'h0C, 32'hFFFFFFFF, 32'h2, "nmi halt");
        chk("rx halted", 32'h0, rx_enable_o);
        rd(8'h14, 32'h8, 32'h8, "nmi status");
        pulse(6, 1, 1'h0);
        for (int i = 0; i < 20; i++)
        begin
            cyc(1);
            chk("no request halted", 32'h0, mem_req_o);
        end
        wr(8'h0C, 32'h0);
        wait_req(1'h1);
        wait_req(1'h0);
        wait_req(1'h1);
        wait_req(1'h0);
        cyc(3);
        chk("status after restart", 32'h3, ns);
        chk("fetch after restart", 32'h2, nf);
        done("nmi");
        complete_run();
    end
endmodule
